/* File: pkg/touch_timing_pkg.sv */
// Constants, types and helpers shared by the touch sensing timing block
package touch_timing_pkg;

    // Clock and timebase
    localparam int CLK_PERIOD_NS      = 10;                                       // 100 MHz core clock
    localparam int TICK_MS            = 35;                                       // Timebase unit
    localparam int TICK_CYCLES        = TICK_MS * 1000000 / CLK_PERIOD_NS;        // Cycles per tick
    localparam int SAMPLE_BASE_US     = 320;                                      // Shortest sample time
    localparam int SAMPLE_UNIT_CYCLES = SAMPLE_BASE_US * 1000 / CLK_PERIOD_NS;    // Cycles per 320us

    // Register offsets
    localparam logic [7:0] ADDR_TOUCH_TIMING = 8'h22;
    localparam logic [7:0] ADDR_HOLD_THRESH  = 8'h23;
    localparam logic [7:0] ADDR_AVG_SAMPLING = 8'h24;

    // Reset values
    localparam logic [7:0] RST_TOUCH_TIMING = 8'hA4;
    localparam logic [7:0] RST_HOLD_THRESH  = 8'h07;
    localparam logic [7:0] RST_AVG_SAMPLING = 8'h39;

    // Writable bit masks, reserved bits read zero
    localparam logic [7:0] MASK_TOUCH_TIMING = 8'hFF;
    localparam logic [7:0] MASK_HOLD_THRESH  = 8'h0F;
    localparam logic [7:0] MASK_AVG_SAMPLING = 8'h7F;

    // Field positions
    localparam int HOLD_RECAL_LSB = 4;    // hold_recal_time
    localparam int REPEAT_LSB     = 0;    // repeat_interval
    localparam int HOLD_THR_LSB   = 0;    // press-and-hold threshold
    localparam int AVG_LSB        = 4;    // sample_count_sel
    localparam int SAMP_LSB       = 2;    // per_sample_duration
    localparam int CYCLE_LSB      = 0;    // cycle period

    // Sizes
    localparam int NUM_CH   = 6;          // Sensor inputs
    localparam int TIME_W   = 9;          // Tick counters, up to 320 ticks
    localparam int SAMPLE_W = 16;         // Raw per-sample count
    localparam int ACC_W    = 24;         // Accumulator and base count
    localparam int TMR_W    = 24;         // Sample timer
    localparam logic [2:0] NO_CHANNEL = 3'h7;

    // Recalibration limits in milliseconds, indexed by code
    localparam int HOLD_RECAL_TIME_MS [16] = '{560, 840, 1120, 1400, 1680, 2240, 2800, 3360,
                                       3920, 4480, 5600, 6720, 7840, 8906, 10080, 11200};

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_SLEEP  = 3'b100
    } seq_state_t;

    // Recalibration limit in ticks, rounded down
    function automatic logic [TIME_W-1:0] maxDurTicks(input logic [3:0] code);
        return TIME_W'(HOLD_RECAL_TIME_MS[code] / TICK_MS);
    endfunction : maxDurTicks

    // Linear (code+1) ticks for repeat, hold and cycle settings
    function automatic logic [TIME_W-1:0] stepTicks(input logic [3:0] code);
        return TIME_W'(code) + TIME_W'(1);
    endfunction : stepTicks

endpackage : touch_timing_pkg

/* File: design/tick_timebase.sv */
// Free-running 35ms timebase that strobes one cycle per period
`timescale 1ns/1ps
module tick_timebase #(
    parameter int TICK_CYCLES = touch_timing_pkg::TICK_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic reset_n,
    output logic      tick
);
    import touch_timing_pkg::*;

    localparam int CNT_W = $clog2(TICK_CYCLES + 1);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(TICK_CYCLES - 1);

    logic [CNT_W-1:0] count;    // Cycles into the current period

    // Divider; tick marks the first cycle of each period, while count is zero
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= '0;
            tick  <= 1'b0;
        end else if (count == LAST) begin
            count <= '0;
            tick  <= 1'b1;
        end else begin
            count <= count + CNT_W'(1);
            tick  <= 1'b0;
        end
    end

    // Tick only while the divider count is zero
    a_tick_spacing: assert property (@(posedge sys_clk) disable iff (!reset_n)
        tick |-> (count == '0)) else $error("tick out of step with divider");

endmodule : tick_timebase

/* File: design/touch_sense_timing_control.sv */
// Timing registers, sensing sequencer and per-input touch timers
`timescale 1ns/1ps
module touch_sense_timing_control #(
    parameter int TICK_CYCLES        = touch_timing_pkg::TICK_CYCLES,
    parameter int SAMPLE_UNIT_CYCLES = touch_timing_pkg::SAMPLE_UNIT_CYCLES
) (
    input  wire logic                                   sys_clk,
    input  wire logic                                   reset_n,
    input  wire logic [7:0]                             regAddr,
    input  wire logic [7:0]                             regWrData,
    input  wire logic                                   regWrite,
    output logic      [7:0]                             regRdData,
    input  wire logic                                   activeState,
    input  wire logic [touch_timing_pkg::NUM_CH-1:0]    channelEnable,
    input  wire logic                                   hold_recal_enable,
    input  wire logic [touch_timing_pkg::NUM_CH-1:0]    input_repeat_enable,
    input  wire logic [touch_timing_pkg::NUM_CH-1:0]    touchDetected,
    input  wire logic [touch_timing_pkg::SAMPLE_W-1:0]  sampleValue,
    output logic                                        sampleStart,
    output logic      [2:0]                             sampleChannel,
    output logic                                        lowPower,
    output logic                                        resultValid,
    output logic      [2:0]                             resultChannel,
    output logic      [touch_timing_pkg::ACC_W-1:0]     baseCount,
    output logic      [touch_timing_pkg::NUM_CH-1:0]    recalRequest,
    output logic      [touch_timing_pkg::NUM_CH-1:0]    pressHold,
    output logic      [touch_timing_pkg::NUM_CH-1:0]    repeatPulse,
    output logic      [touch_timing_pkg::NUM_CH-1:0]    touchEvent
);
    import touch_timing_pkg::*;

    // Configuration registers
    logic [7:0]        touch_timing_config;      // Recal limit and repeat interval
    logic [7:0]        hold_threshold_config;    // Press-and-hold threshold
    logic [7:0]        averaging_sampling_config;// Averaging, sample time, cycle period

    // Decoded fields
    logic [3:0]        hold_recal_time;
    logic [3:0]        repeat_interval;
    logic [3:0]        holdThreshold;
    logic [TIME_W-1:0] maxLimit;                 // Recal limit in ticks
    logic [TIME_W-1:0] repeatLimit;              // Repeat interval in ticks
    logic [TIME_W-1:0] holdLimit;                // Hold threshold in ticks

    // Sequencer
    seq_state_t        state;
    seq_state_t        next_state;
    logic              tick;                     // 35ms strobe
    logic [TIME_W-1:0] cycleTicks;               // Ticks since cycle start
    logic [TIME_W-1:0] cyclePeriod;              // Latched cycle period in ticks
    logic [2:0]        curAvg;                   // Latched sample_count_sel
    logic [1:0]        curSamp;                  // Latched per_sample_duration
    logic [NUM_CH-1:0] curMask;                  // Latched enabled channels
    logic [2:0]        chanIdx;                  // Channel being sampled
    logic [7:0]        sampleIdx;                // Sample number within channel
    logic [TMR_W-1:0]  sampleTimer;              // Cycles into current sample
    logic [ACC_W-1:0]  accum;                    // Running sum of samples
    logic              lastSample;               // Final cycle of a sample
    logic              chanDone;                 // Final cycle of a channel
    logic [2:0]        nextChan;                 // Following enabled channel
    logic [2:0]        firstChan;                // First enabled channel now
    logic [ACC_W-1:0]  sumNow;                   // Sum including current sample

    // Per-input timers
    logic [TIME_W-1:0] touchTicks [NUM_CH];      // Ticks the pad has been held
    logic [TIME_W-1:0] repCnt     [NUM_CH];      // Ticks since last repeat
    logic [NUM_CH-1:0] prevTouch;                // Touch state one cycle ago

    // Lowest enabled channel at or above start, NO_CHANNEL if none
    function automatic logic [2:0] firstEnabled(input logic [NUM_CH-1:0] mask, input logic [3:0] from);
        logic [2:0] found;
        found = NO_CHANNEL;
        for (int k = NUM_CH - 1; k >= 0; k--) begin
            if (mask[k] && (k >= int'(from))) begin
                found = 3'(k);
            end
        end
        return found;
    endfunction : firstEnabled

    // Length of one sample in cycles
    function automatic logic [TMR_W-1:0] sampleLen(input logic [1:0] code);
        return TMR_W'(SAMPLE_UNIT_CYCLES) << code;
    endfunction : sampleLen

    // Shared 35ms timebase
    tick_timebase #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .tick    (tick)
    );

    // Field decode
    assign hold_recal_time = touch_timing_config[HOLD_RECAL_LSB +: 4];
    assign repeat_interval = touch_timing_config[REPEAT_LSB +: 4];
    assign holdThreshold   = hold_threshold_config[HOLD_THR_LSB +: 4];
    assign maxLimit        = maxDurTicks(hold_recal_time);
    assign repeatLimit     = stepTicks(repeat_interval);
    assign holdLimit       = stepTicks(holdThreshold);

    // Register writes; reserved bits stay zero
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            touch_timing_config       <= RST_TOUCH_TIMING;
            hold_threshold_config     <= RST_HOLD_THRESH;
            averaging_sampling_config <= RST_AVG_SAMPLING;
        end else if (regWrite) begin
            unique case (regAddr)
                ADDR_TOUCH_TIMING: touch_timing_config       <= regWrData & MASK_TOUCH_TIMING;
                ADDR_HOLD_THRESH:  hold_threshold_config     <= regWrData & MASK_HOLD_THRESH;
                ADDR_AVG_SAMPLING: averaging_sampling_config <= regWrData & MASK_AVG_SAMPLING;
                default: ;                                   // Unmapped writes ignored
            endcase
        end
    end

    // Registered read data, one cycle behind the address
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            regRdData <= 8'h00;
        end else begin
            unique case (regAddr)
                ADDR_TOUCH_TIMING: regRdData <= touch_timing_config;
                ADDR_HOLD_THRESH:  regRdData <= hold_threshold_config;
                ADDR_AVG_SAMPLING: regRdData <= averaging_sampling_config;
                default:           regRdData <= 8'h00;       // Unmapped reads zero
            endcase
        end
    end

    // Sequencer decode
    always_comb begin
        firstChan  = firstEnabled(channelEnable, 4'h0);
        nextChan   = firstEnabled(curMask, {1'b0, chanIdx} + 4'h1);
        lastSample = (state == ST_SAMPLE) && (sampleTimer == sampleLen(curSamp) - TMR_W'(1));
        chanDone   = lastSample && (sampleIdx == 8'((9'h001 << curAvg) - 9'h001));
        sumNow     = accum + ACC_W'(sampleValue);
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                // Active state only; standby sensing is elsewhere
                if (activeState) begin
                    next_state = (firstChan == NO_CHANNEL) ? ST_SLEEP : ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                // Never cut a channel short; cycle stretches instead
                if (chanDone && nextChan == NO_CHANNEL) begin
                    next_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                // Low power until the programmed period has elapsed
                if (cycleTicks >= cyclePeriod) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // Sequencer state and cycle timing
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state       <= ST_IDLE;
            cycleTicks  <= '0;
            cyclePeriod <= stepTicks({2'b00, RST_AVG_SAMPLING[CYCLE_LSB +: 2]});
            curAvg      <= RST_AVG_SAMPLING[AVG_LSB +: 3];
            curSamp     <= RST_AVG_SAMPLING[SAMP_LSB +: 2];
            curMask     <= '0;
        end else begin
            state <= next_state;
            if (state == ST_IDLE && activeState) begin
                // New cycle: settings and channel set held for its length
                cycleTicks  <= '0;
                cyclePeriod <= stepTicks({2'b00, averaging_sampling_config[CYCLE_LSB +: 2]});
                curAvg      <= averaging_sampling_config[AVG_LSB +: 3];
                curSamp     <= averaging_sampling_config[SAMP_LSB +: 2];
                curMask     <= channelEnable;
            end else if (tick && cycleTicks != '1) begin
                cycleTicks <= cycleTicks + TIME_W'(1);
            end
        end
    end

    // Sample timing, channel walk and averaging
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sampleStart   <= 1'b0;
            sampleChannel <= 3'h0;
            chanIdx       <= 3'h0;
            sampleIdx     <= 8'h00;
            sampleTimer   <= '0;
            accum         <= '0;
            resultValid   <= 1'b0;
            resultChannel <= 3'h0;
            baseCount     <= '0;
        end else begin
            sampleStart <= 1'b0;
            resultValid <= 1'b0;
            if (state == ST_IDLE && next_state == ST_SAMPLE) begin
                // First channel of the cycle
                chanIdx       <= firstChan;
                sampleChannel <= firstChan;
                sampleIdx     <= 8'h00;
                sampleTimer   <= '0;
                accum         <= '0;
                sampleStart   <= 1'b1;
            end else if (state == ST_SAMPLE) begin
                if (!lastSample) begin
                    sampleTimer <= sampleTimer + TMR_W'(1);
                end else if (!chanDone) begin
                    // Next sample back to back on the same channel
                    sampleTimer <= '0;
                    sampleIdx   <= sampleIdx + 8'h01;
                    accum       <= sumNow;
                    sampleStart <= 1'b1;
                end else begin
                    // Average, scale by sample length, publish
                    resultValid   <= 1'b1;
                    resultChannel <= chanIdx;
                    baseCount     <= (sumNow >> curAvg) << curSamp;
                    sampleTimer   <= '0;
                    sampleIdx     <= 8'h00;
                    accum         <= '0;
                    if (nextChan != NO_CHANNEL) begin
                        chanIdx       <= nextChan;
                        sampleChannel <= nextChan;
                        sampleStart   <= 1'b1;
                    end
                end
            end
        end
    end

    // Reduced power between sampling and cycle end
    assign lowPower = state[2];

    // Per-input hold, recalibration and repeat timers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            recalRequest <= '0;
            pressHold    <= '0;
            repeatPulse  <= '0;
            touchEvent   <= '0;
            prevTouch    <= '0;
            for (int i = 0; i < NUM_CH; i++) begin
                touchTicks[i] <= '0;
                repCnt[i]     <= '0;
            end
        end else begin
            prevTouch    <= touchDetected;
            recalRequest <= '0;
            repeatPulse  <= '0;
            touchEvent   <= '0;
            for (int i = 0; i < NUM_CH; i++) begin
                if (!touchDetected[i]) begin
                    // Release: short touch on a repeat input is a touch event
                    touchEvent[i] <= prevTouch[i] && input_repeat_enable[i] && !pressHold[i];
                    touchTicks[i] <= '0;
                    repCnt[i]     <= '0;
                    pressHold[i]  <= 1'b0;
                end else if (!input_repeat_enable[i] && pressHold[i]) begin
                    // Repeat withdrawn mid-hold
                    pressHold[i] <= 1'b0;
                end else if (tick) begin
                    if (hold_recal_enable && touchTicks[i] + TIME_W'(1) == maxLimit) begin
                        // Held too long: recalibrate and restart timing
                        recalRequest[i] <= 1'b1;
                        touchTicks[i]   <= '0;
                    end else if (touchTicks[i] != '1) begin
                        touchTicks[i] <= touchTicks[i] + TIME_W'(1);
                    end
                    if (input_repeat_enable[i] && !pressHold[i] && touchTicks[i] + TIME_W'(1) > holdLimit) begin
                        // Strictly longer than threshold
                        pressHold[i] <= 1'b1;
                        repCnt[i]    <= '0;
                    end else if (pressHold[i] && repCnt[i] + TIME_W'(1) == repeatLimit) begin
                        repeatPulse[i] <= 1'b1;
                        repCnt[i]      <= '0;
                    end else if (pressHold[i]) begin
                        repCnt[i] <= repCnt[i] + TIME_W'(1);
                    end
                end
            end
        end
    end

    // Helper: cycles since the last sample start
    logic [TMR_W-1:0] gapCnt;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            gapCnt <= '0;
        end else if (sampleStart) begin
            gapCnt <= TMR_W'(1);
        end else if (gapCnt != '1) begin
            gapCnt <= gapCnt + TMR_W'(1);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_recal_limit: assert property (
        recalRequest[0] |-> $past(touchTicks[0]) + TIME_W'(1) == $past(maxLimit))
        else $error("recalibration not at hold limit");
    a_recal_gated: assert property (
        recalRequest[0] |-> $past(hold_recal_enable) && $past(touchDetected[0]))
        else $error("recalibration without enable or touch");
    a_repeat_interval: assert property (
        repeatPulse[0] |-> $past(repCnt[0]) + TIME_W'(1) == $past(repeatLimit) && $past(pressHold[0]))
        else $error("repeat pulse off its interval");
    a_hold_entry: assert property (
        $rose(pressHold[0]) |-> $past(touchTicks[0]) >= $past(holdLimit) && $past(tick))
        else $error("press-and-hold entered too early");
    a_hold_repeat_only: assert property (
        $rose(pressHold[0]) |-> $past(input_repeat_enable[0]))
        else $error("hold on repeat-disabled input");
    a_touch_class: assert property (
        touchEvent[0] |-> !$past(pressHold[0]) && $past(prevTouch[0]))
        else $error("touch event after press-and-hold");
    a_channel_result: assert property (
        state == ST_SAMPLE && $past(state == ST_SAMPLE) && $changed(chanIdx) |->
        resultValid && resultChannel == $past(chanIdx))
        else $error("channel left before its result");
    a_sample_count: assert property (
        resultValid |-> $past(sampleIdx) == 8'((9'h001 << $past(curAvg)) - 9'h001))
        else $error("result with wrong sample count");
    a_sample_length: assert property (
        sampleStart && $past(state == ST_SAMPLE) |-> gapCnt == sampleLen(curSamp))
        else $error("sample length mismatch");
    a_cycle_period: assert property (
        state == ST_IDLE && $past(state == ST_SLEEP) |-> $past(cycleTicks) >= $past(cyclePeriod))
        else $error("cycle ended before its period");
    a_no_cut: assert property (
        $past(state == ST_SAMPLE) && state != ST_SAMPLE |-> resultValid)
        else $error("sampling cut short");
    a_standby_quiet: assert property (
        state == ST_IDLE && !activeState |=> state == ST_IDLE)
        else $error("sensing outside Active state");

    c_recal:    cover property (recalRequest[0]);
    c_repeat:   cover property (repeatPulse[0] ##1 !repeatPulse[0]);
    c_stretch:  cover property (state == ST_SAMPLE && cycleTicks > cyclePeriod);
    c_result:   cover property (resultValid && resultChannel == 3'h5);

endmodule : touch_sense_timing_control

/* File: dv/touch_pad_model.sv */
// Sensor pad model returning raw counts per channel
`timescale 1ns/1ps
module touch_pad_model (
    input  wire logic        sys_clk,
    input  wire logic        sampleStart,
    input  wire logic [2:0]  sampleChannel,
    output logic      [15:0] sampleValue
);
    logic odd = 1'b0;  // Alternates at each sample start
    // Flip per sample so that averaging is really exercised
    always @(posedge sys_clk) begin
        if (sampleStart) odd <= ~odd;
    end
    // Channel-dependent count, two higher on alternate samples
    assign sampleValue = 16'h1230 + {13'h0, sampleChannel} + (odd ? 16'h2 : 16'h0);
endmodule : touch_pad_model

/* File: dv/touch_sense_timing_control_tb.sv */
// Self-checking bench for the touch timing block
`timescale 1ns/1ps
module touch_sense_timing_control_tb;
    import touch_timing_pkg::*;
    logic        sys_clk, reset_n, regWrite, activeState, hold_recal_enable;
    logic [7:0]  regAddr, regWrData, regRdData, d;
    logic [5:0]  channelEnable, input_repeat_enable, touchDetected;
    logic [5:0]  recalRequest, pressHold, repeatPulse, touchEvent;
    logic [15:0] sampleValue;
    logic        sampleStart, lowPower, resultValid;
    logic [2:0]  sampleChannel, resultChannel;
    logic [23:0] baseCount;
    int          mismatches, tests_run, k, j, waited;
    localparam int TK = 20;  // Cycles per tick in this bench
    // Design with short tick and sample unit
    touch_sense_timing_control #(.TICK_CYCLES(TK), .SAMPLE_UNIT_CYCLES(4)) DUT (
        .sys_clk, .reset_n, .regAddr, .regWrData, .regWrite, .regRdData, .activeState,
        .channelEnable, .hold_recal_enable, .input_repeat_enable, .touchDetected,
        .sampleValue, .sampleStart, .sampleChannel, .lowPower, .resultValid,
        .resultChannel, .baseCount, .recalRequest, .pressHold, .repeatPulse, .touchEvent);
    // Pads on the far side
    touch_pad_model pads (.sys_clk, .sampleStart, .sampleChannel, .sampleValue);
    // Free-running 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Counts one comparison and reports a miss
    task chk(input bit ok, input string m);
        tests_run++;
        if (!ok) begin
            mismatches++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask : chk
    // Verdict and end of run
    task wrap_up;
        if (mismatches == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up
    // Event selected for a bounded wait
    function bit hit(input int s);
        case (s)
            0: return resultValid === 1'b1;
            1: return pressHold[0] === 1'b1;
            2: return repeatPulse[0] === 1'b1;
            default: return recalRequest[0] === 1'b1;
        endcase
    endfunction : hit
    // Waits at most n+1 cycles, gives up on a hang
    task wt(input int s, input int n);
        int i;
        i = 0;
        @(negedge sys_clk);
        while (!hit(s) && i < n) begin
            @(negedge sys_clk);
            i++;
        end
        waited = i;
        chk(hit(s), "event missing");
        if (!hit(s)) wrap_up();
    endtask : wt
    // One-cycle register write
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge sys_clk);
        regAddr = a;
        regWrData = v;
        regWrite = 1'b1;
        @(negedge sys_clk);
        regWrite = 1'b0;
    endtask : wr
    // Register read, data one cycle after address
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge sys_clk);
        regAddr = a;
        @(negedge sys_clk);
        chk(regRdData === e, "register read");
    endtask : rd
    // Main sequence
    initial begin
        {reset_n, regWrite, activeState, hold_recal_enable} = 4'h0;
        {regAddr, regWrData} = 16'h0000;
        {channelEnable, input_repeat_enable, touchDetected} = 18'h0;
        void'($urandom(55330));
        repeat (10) @(negedge sys_clk);
        reset_n = 1'b1;
        rd(8'h22, 8'hA4);
        rd(8'h23, 8'h07);
        rd(8'h24, 8'h39);
        rd(8'h25, 8'h00);
        d = 8'($urandom);
        wr(8'h23, d);
        rd(8'h23, d & 8'h0F);
        wr(8'h24, d);
        rd(8'h24, d & 8'h7F);
        channelEnable = 6'($urandom) | 6'h03;
        // Overrunning fixed set first, then random averaging and sample time
        for (j = 0; j < 2; j++) begin
            d = (j == 0) ? 8'h14 : {1'b0, 3'(1 + $urandom % 3), 4'($urandom)};
            wr(8'h24, d);
            activeState = 1'b1;
            for (k = 0; k < 6; k++) if (channelEnable[k]) begin
                wt(0, 300);
                chk(resultChannel === 3'(k) && baseCount === ((24'h1231 + k) << d[3:2]), "result");
            end
            chk(lowPower === 1'b1, "sleep after sampling");
            activeState = 1'b0;
        end
        wr(8'h22, 8'h00);
        wr(8'h23, 8'h00);
        input_repeat_enable = 6'h01;
        touchDetected = 6'h03;
        wt(1, 80);
        chk(waited >= TK && waited < 2 * TK, "hold not after threshold");
        chk(pressHold[1] === 1'b0, "hold on plain input");
        wt(2, 40);
        chk(waited == TK - 1, "repeat interval");
        for (k = 0; k < 400; k++) begin
            @(negedge sys_clk);
            chk(recalRequest === 6'h00, "recal while off");
        end
        touchDetected = 6'h00;
        @(negedge sys_clk);
        chk(pressHold === 6'h00, "hold after release");
        // Short touch on both inputs: only the repeat input reports it
        touchDetected = 6'h03;
        repeat (3) @(negedge sys_clk);
        touchDetected = 6'h00;
        @(negedge sys_clk);
        chk(touchEvent === 6'h01, "short touch event");
        hold_recal_enable = 1'b1;
        touchDetected = 6'h01;
        wt(3, 360);
        chk(waited >= (HOLD_RECAL_TIME_MS[0] / TICK_MS - 1) * TK && waited < (HOLD_RECAL_TIME_MS[0] / TICK_MS) * TK,
            "recal time");
        wrap_up();
    end
endmodule : touch_sense_timing_control_tb
